// ===== hw/audio_serial_format_engine_defs.vh
/*
 * Constants for the serial audio format engine: register indices, field
 * positions, format and word-length codes, reset values.
 * Assumes a byte address of four times the register index on the bus.
 */
`ifndef AUDIO_SERIAL_FORMAT_ENGINE_DEFS_VH
`define AUDIO_SERIAL_FORMAT_ENGINE_DEFS_VH

// ----------------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------------
`define IDX_PRIMARY_RX_FORMAT_CTRL 6'h0c
`define IDX_PRIMARY_TX_FORMAT_CTRL 6'h0d
`define IDX_SECONDARY_PORT_FORMAT_CTRL 6'h0e
`define IDX_FORMAT_STATUS 6'h0f

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FLD_FORMAT_LO 0
`define FLD_WORD_LENGTH_LO 2
`define FLD_FRAME_POLARITY 4
`define FLD_BITCLOCK_INVERT 5
`define FLD_SECONDARY_ENABLE 6

// ----------------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------------
`define FMT_RIGHT_JUST 2'h0
`define FMT_LEFT_JUST 2'h1
`define FMT_I2S 2'h2
`define FMT_DSP 2'h3
`define WL_16 2'h0
`define WL_20 2'h1
`define WL_24 2'h2
`define WL_32 2'h3
`define FORMAT_CTRL_RESET 8'h0a
`define AUTO16_PERIOD_BITS 7'h20
`define PRIMARY_DSP_WORDS 3'h6
`define SECONDARY_DSP_WORDS 3'h2

`endif

// ===== hw/bclk_edge_sync.v
/*
 * Synchroniser and edge finder for one serial audio port: brings bit clock,
 * frame clock and data lines into the system clock domain and flags the
 * sampling edge and the launching edge of the bit clock.
 * Assumes the bit clock is well below half the system clock rate.
 */
`timescale 1ns/1ps
module bclk_edge_sync #(
    parameter WIDTH = 1
) (
    input wire sys_clk_i,
    input wire rst_b_i,
    input wire bclk_i,
    input wire lrclk_i,
    input wire [WIDTH-1:0] data_i,
    input wire invert_i,
    output wire sample_o,
    output wire launch_o,
    output wire lrclk_o,
    output wire [WIDTH-1:0] data_o
);
    reg bclk_s1, bclk_s2, bclk_s3;
    reg lr_s1, lr_s2;
    reg [WIDTH-1:0] dat_s1, dat_s2;
    wire rise;
    wire fall;

    // ------------------------------------------------------------------
    // Two-stage synchronisers
    // ------------------------------------------------------------------
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bclk_s1 <= 1'b0;
            bclk_s2 <= 1'b0;
            bclk_s3 <= 1'b0;
            lr_s1 <= 1'b0;
            lr_s2 <= 1'b0;
            dat_s1 <= {WIDTH{1'b0}};
            dat_s2 <= {WIDTH{1'b0}};
        end else begin
            bclk_s1 <= bclk_i;
            bclk_s2 <= bclk_s1;
            bclk_s3 <= bclk_s2;
            lr_s1 <= lrclk_i;
            lr_s2 <= lr_s1;
            dat_s1 <= data_i;
            dat_s2 <= dat_s1;
        end
    end

    // ------------------------------------------------------------------
    // Edge selection by polarity
    // ------------------------------------------------------------------
    assign rise = bclk_s2 & ~bclk_s3;
    assign fall = ~bclk_s2 & bclk_s3;
    assign sample_o = invert_i ? fall : rise;
    assign launch_o = invert_i ? rise : fall;
    assign lrclk_o = lr_s2;
    assign data_o = dat_s2;
endmodule

// ===== hw/audio_serial_format_engine.v
/*
 * Serial audio format engine: primary receiver (three data lines),
 * primary transmitter and secondary stereo port, with Wishbone registers.
 * Assumes the far side drives all bit and frame clocks (slave operation)
 * and that the bit clock runs below a quarter of sys_clk_i.
 */
// Summary of operation
// - I2S receive: MSB on second sampling edge after any frame-clock change.
// - I2S transmit: MSB launched on first launch edge after frame change.
// - I2S: frame clock low marks left word, high marks right.
// - DSP A receive: L1 MSB on second edge after rise; then 2, 3.
// - Secondary DSP receive keeps one stereo pair, ignores later words.
// - DSP A transmit: left MSB one edge after rise, right contiguous.
// - DSP B receive: L1 MSB on first edge after rise, same order.
// - DSP B transmit: MSB launched on the edge of the frame rise.
// - Default: receive samples data and frame clock rising; transmit reads frame clock and changes output falling.
// - Bit 5 swaps sampling and launching edges of the bit clock.
// - Bit 4 inverts frame clock, or picks DSP mode B; resets 0.
// - Bits 1:0 select DSP, I2S, left or right justified; reset I2S.
// - Bits 3:2 select 32, 24, 20 or 16 bits; reset 24.
// - Secondary control adds enable bit 6, reset 0, disabling the port.
// - Right justified with 32-bit setting runs at 24 bits.
// - Words become signed 24 bits: short ones zero padded, 32 truncated.
// - Exactly 32 bit clocks per frame forces 16-bit receive words, except in DSP.
`timescale 1ns/1ps
`include "audio_serial_format_engine_defs.vh"
module audio_serial_format_engine (
    input wire sys_clk_i,
    input wire rst_b_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire prx_bclk_i,
    input wire prx_lrclk_i,
    input wire [2:0] receive_data_lines_i,
    output wire [71:0] prx_left_o,
    output wire [71:0] prx_right_o,
    output wire prx_valid_o,
    input wire ptx_bclk_i,
    input wire ptx_lrclk_i,
    output wire ptx_data_o,
    input wire [23:0] ptx_left_i,
    input wire [23:0] ptx_right_i,
    output wire ptx_taken_o,
    input wire sec_bclk_i,
    input wire sec_lrclk_i,
    input wire sec_data_i,
    output wire [23:0] srx_left_o,
    output wire [23:0] srx_right_o,
    output wire srx_valid_o,
    output wire stx_data_o,
    input wire [23:0] stx_left_i,
    input wire [23:0] stx_right_i,
    output wire stx_taken_o
);
    reg [5:0] primary_rx_format_ctrl;
    reg [5:0] primary_tx_format_ctrl;
    reg [6:0] secondary_port_format_ctrl;
    wire secondary_port_enable;
    wire wb_req;
    wire [5:0] wb_idx;
    wire [1:0] auto16_flag;
    wire prx_smp, prx_lr, sec_smp, sec_lch, sec_lr, ptx_lch, ptx_lr, sec_d;
    wire [2:0] prx_d;
    wire [15:0] rx_cfg;
    wire [15:0] tx_cfg;
    wire [1:0] rx_smp, rx_lr, tx_lch, tx_lr, rx_en, tx_en;
    wire [5:0] rx_dat;
    wire [143:0] rx_left, rx_right;
    wire [1:0] rx_valid, tx_dout, tx_taken;
    wire [47:0] tx_left, tx_right;

    // ------------------------------------------------------------------
    // Word length helpers
    // ------------------------------------------------------------------
    function [5:0] wl_bits;
        input [1:0] code;
        begin
            case (code)
                `WL_16: wl_bits = 6'h10;
                `WL_20: wl_bits = 6'h14;
                `WL_24: wl_bits = 6'h18;
                default: wl_bits = 6'h20;
            endcase
        end
    endfunction

    function [23:0] to_24;
        input [31:0] w;
        input [1:0] code;
        begin
            case (code)
                `WL_16: to_24 = {w[15:0], 8'h00};
                `WL_20: to_24 = {w[19:0], 4'h0};
                `WL_24: to_24 = w[23:0];
                default: to_24 = w[31:8];
            endcase
        end
    endfunction

    function [1:0] eff_wl;
        input [7:0] cfg;
        input auto16;
        begin
            if (auto16 && cfg[1:0] != `FMT_DSP)
                eff_wl = `WL_16;
            else if (cfg[1:0] == `FMT_RIGHT_JUST && cfg[3:2] == `WL_32)
                eff_wl = `WL_24;
            else
                eff_wl = cfg[3:2];
        end
    endfunction

    // ------------------------------------------------------------------
    // Wishbone register file
    // ------------------------------------------------------------------
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_idx = wb_adr_i[7:2];
    assign secondary_port_enable = secondary_port_format_ctrl[`FLD_SECONDARY_ENABLE];

    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            primary_rx_format_ctrl <= 6'h0a;
            primary_tx_format_ctrl <= 6'h0a;
            secondary_port_format_ctrl <= 7'h0a;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]) begin
                case (wb_idx)
                    `IDX_PRIMARY_RX_FORMAT_CTRL: primary_rx_format_ctrl <= wb_dat_i[5:0];
                    `IDX_PRIMARY_TX_FORMAT_CTRL: primary_tx_format_ctrl <= wb_dat_i[5:0];
                    `IDX_SECONDARY_PORT_FORMAT_CTRL: begin
                        secondary_port_format_ctrl <= wb_dat_i[6:0];
                    end
                    default: ;
                endcase
            end
            if (wb_req && !wb_we_i) begin
                case (wb_idx)
                    `IDX_PRIMARY_RX_FORMAT_CTRL: wb_dat_o <= {26'h0, primary_rx_format_ctrl};
                    `IDX_PRIMARY_TX_FORMAT_CTRL: wb_dat_o <= {26'h0, primary_tx_format_ctrl};
                    `IDX_SECONDARY_PORT_FORMAT_CTRL: begin
                        wb_dat_o <= {25'h0, secondary_port_format_ctrl};
                    end
                    `IDX_FORMAT_STATUS: wb_dat_o <= {30'h0, auto16_flag};
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end else begin
                wb_dat_o <= 32'h00000000;
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    bclk_edge_sync #(.WIDTH(3)) u_prx_sync (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .bclk_i(prx_bclk_i),
        .lrclk_i(prx_lrclk_i),
        .data_i(receive_data_lines_i),
        .invert_i(primary_rx_format_ctrl[`FLD_BITCLOCK_INVERT]),
        .sample_o(prx_smp),
        .launch_o(),
        .lrclk_o(prx_lr),
        .data_o(prx_d)
    );

    bclk_edge_sync #(.WIDTH(1)) u_ptx_sync (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .bclk_i(ptx_bclk_i),
        .lrclk_i(ptx_lrclk_i),
        .data_i(1'b0),
        .invert_i(primary_tx_format_ctrl[`FLD_BITCLOCK_INVERT]),
        .sample_o(),
        .launch_o(ptx_lch),
        .lrclk_o(ptx_lr),
        .data_o()
    );

    bclk_edge_sync #(.WIDTH(1)) u_sec_sync (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .bclk_i(sec_bclk_i),
        .lrclk_i(sec_lrclk_i),
        .data_i(sec_data_i),
        .invert_i(secondary_port_format_ctrl[`FLD_BITCLOCK_INVERT]),
        .sample_o(sec_smp),
        .launch_o(sec_lch),
        .lrclk_o(sec_lr),
        .data_o(sec_d)
    );

    assign rx_cfg = {1'b0, secondary_port_format_ctrl, 2'b00, primary_rx_format_ctrl};
    assign tx_cfg = {1'b0, secondary_port_format_ctrl, 2'b00, primary_tx_format_ctrl};
    assign rx_smp = {sec_smp, prx_smp};
    assign rx_lr = {sec_lr, prx_lr};
    assign rx_dat = {2'b00, sec_d, prx_d};
    assign rx_en = {secondary_port_enable, 1'b1};
    assign tx_lch = {sec_lch, ptx_lch};
    assign tx_lr = {sec_lr, ptx_lr};
    assign tx_en = {secondary_port_enable, 1'b1};
    assign tx_left = {stx_left_i, ptx_left_i};
    assign tx_right = {stx_right_i, ptx_right_i};

    // ------------------------------------------------------------------
    // Receivers: port 0 primary, port 1 secondary
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : rx
            wire [7:0] cfg = rx_cfg[g*8 +: 8];
            wire [1:0] fmt = cfg[1:0];
            wire lrp = cfg[`FLD_FRAME_POLARITY];
            wire dsp = (fmt == `FMT_DSP);
            wire rj = (fmt == `FMT_RIGHT_JUST);
            wire lr = rx_lr[g];
            wire [2:0] d = rx_dat[g*3 +: 3];
            wire left_lvl = ((fmt == `FMT_I2S) ? 1'b0 : 1'b1) ^ lrp;
            wire off = dsp ? ~lrp : (fmt == `FMT_I2S);
            wire [2:0] maxw = (g == 0) ? `PRIMARY_DSP_WORDS : `SECONDARY_DSP_WORDS;
            reg lr_q, busy, cur_left, pub, auto16, valid;
            reg [5:0] bitn;
            reg [2:0] wordn;
            reg [6:0] per;
            reg [95:0] sh;
            reg [71:0] lbuf, rbuf, lout, rout;
            wire [1:0] weff = eff_wl(cfg, auto16);
            wire [5:0] wlb = wl_bits(weff);
            wire start = dsp ? (lr & ~lr_q) : (lr ^ lr_q);
            wire take = start ? (~off & ~rj) : (busy & ~rj);
            wire last = (bitn + 6'h01 == wlb);
            integer i;

            always @(posedge sys_clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    lr_q <= 1'b0;
                    busy <= 1'b0;
                    cur_left <= 1'b0;
                    pub <= 1'b0;
                    auto16 <= 1'b0;
                    valid <= 1'b0;
                    bitn <= 6'h00;
                    wordn <= 3'h0;
                    per <= 7'h00;
                    sh <= 96'h0;
                    lbuf <= 72'h0;
                    rbuf <= 72'h0;
                    lout <= 72'h0;
                    rout <= 72'h0;
                end else begin
                    valid <= pub;
                    pub <= 1'b0;
                    if (pub) begin
                        lout <= lbuf;
                        rout <= rbuf;
                    end
                    if (!rx_en[g]) begin
                        busy <= 1'b0;
                        bitn <= 6'h00;
                        lr_q <= lr;
                    end else if (rx_smp[g]) begin
                        lr_q <= lr;
                        for (i = 0; i < 3; i = i + 1)
                            sh[i*32 +: 32] <= {sh[i*32 +: 31], d[i]};
                        // Frame period measure for 16-bit auto detection
                        if (lr & ~lr_q) begin
                            per <= 7'h01;
                            auto16 <= (per == `AUTO16_PERIOD_BITS);
                        end else if (per != 7'h7f) begin
                            per <= per + 7'h01;
                        end
                        if (start) begin
                            if (busy & last & ~dsp & ~rj) begin
                                // Tight frame: last bit of a word on the frame edge
                                for (i = 0; i < 3; i = i + 1) begin
                                    if (cur_left)
                                        lbuf[i*24 +: 24] <=
                                            to_24({sh[i*32 +: 31], d[i]}, weff);
                                    else
                                        rbuf[i*24 +: 24] <=
                                            to_24({sh[i*32 +: 31], d[i]}, weff);
                                end
                                pub <= ~cur_left;
                            end
                            busy <= 1'b1;
                            wordn <= 3'h0;
                            bitn <= take ? 6'h01 : 6'h00;
                            cur_left <= (lr == left_lvl);
                            if (rj) begin
                                // Right justified: word ends just before the change
                                for (i = 0; i < 3; i = i + 1) begin
                                    if (lr_q == left_lvl)
                                        lbuf[i*24 +: 24] <= to_24(sh[i*32 +: 32], weff);
                                    else
                                        rbuf[i*24 +: 24] <= to_24(sh[i*32 +: 32], weff);
                                end
                                pub <= (lr_q != left_lvl);
                            end
                        end else if (take) begin
                            if (last) begin
                                bitn <= 6'h00;
                                wordn <= wordn + 3'h1;
                                if (dsp) begin
                                    // Channel order L1 R1 L2 R2 L3 R3 on line 0
                                    if (wordn[0])
                                        rbuf[wordn[2:1]*24 +: 24] <=
                                            to_24({sh[30:0], d[0]}, weff);
                                    else
                                        lbuf[wordn[2:1]*24 +: 24] <=
                                            to_24({sh[30:0], d[0]}, weff);
                                    if (wordn + 3'h1 == maxw) begin
                                        busy <= 1'b0;
                                        pub <= 1'b1;
                                    end
                                end else begin
                                    busy <= 1'b0;
                                    for (i = 0; i < 3; i = i + 1) begin
                                        if (cur_left)
                                            lbuf[i*24 +: 24] <=
                                                to_24({sh[i*32 +: 31], d[i]}, weff);
                                        else
                                            rbuf[i*24 +: 24] <=
                                                to_24({sh[i*32 +: 31], d[i]}, weff);
                                    end
                                    pub <= ~cur_left;
                                end
                            end else begin
                                bitn <= bitn + 6'h01;
                            end
                        end
                    end
                end
            end
            assign rx_left[g*72 +: 72] = lout;
            assign rx_right[g*72 +: 72] = rout;
            assign rx_valid[g] = valid;
            assign auto16_flag[g] = auto16;
        end
    endgenerate

    // ------------------------------------------------------------------
    // Transmitters: port 0 primary, port 1 secondary
    // ------------------------------------------------------------------
    generate
        for (g = 0; g < 2; g = g + 1) begin : tx
            reg lr_q, pend, second, dout, taken;
            reg [5:0] bitn;
            reg [6:0] cnt, hl;
            reg [31:0] sh;
            reg [23:0] rhold;
            wire [7:0] cfg = tx_cfg[g*8 +: 8];
            wire [1:0] fmt = cfg[1:0];
            wire lrp = cfg[`FLD_FRAME_POLARITY];
            wire dsp = (fmt == `FMT_DSP);
            wire rj = (fmt == `FMT_RIGHT_JUST);
            wire lr = tx_lr[g];
            wire left_lvl = ((fmt == `FMT_I2S) ? 1'b0 : 1'b1) ^ lrp;
            wire [1:0] weff = eff_wl(cfg, 1'b0);
            wire [5:0] wlb = wl_bits(weff);
            wire evt = dsp ? (lr & ~lr_q) : (lr ^ lr_q);
            wire imm = dsp ? lrp : (fmt == `FMT_LEFT_JUST);
            wire [6:0] idx = (lr ^ lr_q) ? 7'h00 : cnt + 7'h01;
            wire rj_go = rj & (idx == hl - {1'b0, wlb});
            wire go = rj ? rj_go : ((evt & imm) | pend);
            wire is_left = dsp | (lr == left_lvl);
            wire [23:0] word = is_left ? tx_left[g*24 +: 24] : rhold;

            always @(posedge sys_clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    lr_q <= 1'b0;
                    pend <= 1'b0;
                    second <= 1'b0;
                    dout <= 1'b0;
                    taken <= 1'b0;
                    bitn <= 6'h00;
                    cnt <= 7'h00;
                    hl <= 7'h00;
                    sh <= 32'h0;
                    rhold <= 24'h0;
                end else begin
                    taken <= 1'b0;
                    if (!tx_en[g]) begin
                        dout <= 1'b0;
                        pend <= 1'b0;
                        bitn <= 6'h00;
                        lr_q <= lr;
                    end else if (tx_lch[g]) begin
                        lr_q <= lr;
                        cnt <= (cnt == 7'h7f) ? cnt : idx;
                        if (lr ^ lr_q)
                            hl <= cnt + 7'h01;
                        pend <= ~rj & evt & ~imm;
                        if (go) begin
                            dout <= word[23];
                            sh <= {word[22:0], 9'h000};
                            bitn <= 6'h01;
                            second <= 1'b0;
                            if (is_left) begin
                                rhold <= tx_right[g*24 +: 24];
                                taken <= 1'b1;
                            end
                        end else if (bitn == wlb) begin
                            if (dsp && !second) begin
                                // Right word follows with no gap
                                dout <= rhold[23];
                                sh <= {rhold[22:0], 9'h000};
                                bitn <= 6'h01;
                                second <= 1'b1;
                            end else begin
                                dout <= 1'b0;
                                bitn <= 6'h00;
                            end
                        end else if (bitn != 6'h00) begin
                            dout <= sh[31];
                            sh <= {sh[30:0], 1'b0};
                            bitn <= bitn + 6'h01;
                        end
                    end
                end
            end
            assign tx_dout[g] = dout;
            assign tx_taken[g] = taken;
        end
    endgenerate

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prx_left_o = rx_left[71:0];
    assign prx_right_o = rx_right[71:0];
    assign prx_valid_o = rx_valid[0];
    assign srx_left_o = rx_left[95:72];
    assign srx_right_o = rx_right[95:72];
    assign srx_valid_o = rx_valid[1];
    assign ptx_data_o = tx_dout[0];
    assign ptx_taken_o = tx_taken[0];
    assign stx_data_o = tx_dout[1];
    assign stx_taken_o = tx_taken[1];
endmodule

// ===== test/audio_serial_format_engine_chk.sv
/* Checker for bus answers and result pulses of the format engine.
   Assumes it is bound to the engine top by port name. */
`timescale 1ns/1ps
module audio_serial_format_engine_chk (
    input wire sys_clk_i,
    input wire rst_b_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire prx_valid_o,
    input wire ptx_taken_o,
    input wire srx_valid_o,
    input wire stx_taken_o
);
    // ----------------------------------------------------------
    // Properties
    // ----------------------------------------------------------
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    a_ack_next: assert property (s_req |=> wb_ack_o) else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data idle");
    a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper");
    a_rx_gap: assert property (prx_valid_o |=> !prx_valid_o [*8]) else $error("rx pulse");
    a_srx_gap: assert property (srx_valid_o |=> !srx_valid_o [*8]) else $error("srx pulse");
    a_tx_gap: assert property (ptx_taken_o |=> !ptx_taken_o [*8]) else $error("tx pulse");
    a_stx_gap: assert property (stx_taken_o |=> !stx_taken_o [*8]) else $error("stx pulse");
endmodule
bind audio_serial_format_engine audio_serial_format_engine_chk chk_u (.*);

// ===== test/host_serial_model.sv
/* Host model sending I2S frames, 16 or 32 bit clocks per half frame.
   Assumes a 160 ns bit clock that stands still between frames. */
`timescale 1ns/1ps
module host_serial_model (
    output logic bclk_o,
    output logic lrclk_o,
    output logic [2:0] data_o
);
    // ----------------------------------------------------------
    // Frame driver
    // ----------------------------------------------------------
    logic [2:0] tail = 0;
    initial begin
        bclk_o = 1;
        lrclk_o = 1;
        data_o = 0;
    end
    task automatic half(input logic [23:0] w, input logic lv, input int n);
        for (int i = 0; i < n; i++) begin
            bclk_o = 0;
            if (i == 0) lrclk_o = lv;
            data_o = (i == 0) ? tail : (i <= 24) ? {w[24-i], ~w[24-i], w[24-i]} : ~data_o;
            #80 bclk_o = 1;
            #80;
        end
        tail = (n < 24) ? {w[24-n], ~w[24-n], w[24-n]} : ~data_o;
    endtask
    task automatic frame(input logic [23:0] l, r, input int n);
        #2;
        half(l, 1'b0, n);
        half(r, 1'b1, n);
    endtask
endmodule

// ===== test/tb_top.sv
/* Bench: registers over Wishbone and I2S receive at 24, 20, 16 bits.
   Assumes the host model and checker are compiled first. */
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
    logic sys_clk_i = 0, rst_b_i = 0, cyc = 0, stb = 0, we = 0, ack, bclk, lr, pv;
    logic [7:0] adr = 0;
    logic [31:0] wdat = 0, rdat, q, seed = 32'h8eaca423;
    logic [71:0] pl, pr, ql[$];
    logic [23:0] tl = 0, tr = 0, l, r, m;
    logic [2:0] din;
    int failures = 0, n_tests = 0, cycles = 0;
    // ----------------------------------------------------------
    // Harness
    // ----------------------------------------------------------
    always #5 sys_clk_i = ~sys_clk_i;
    host_serial_model host_u (.bclk_o(bclk), .lrclk_o(lr), .data_o(din));
    audio_serial_format_engine dut_u (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .prx_bclk_i(bclk),
        .prx_lrclk_i(lr), .receive_data_lines_i(din), .prx_left_o(pl), .prx_right_o(pr),
        .prx_valid_o(pv), .ptx_bclk_i(bclk), .ptx_lrclk_i(lr), .ptx_data_o(),
        .ptx_left_i(tl), .ptx_right_i(tr), .ptx_taken_o(), .sec_bclk_i(bclk),
        .sec_lrclk_i(lr), .sec_data_i(din[1]), .srx_left_o(), .srx_right_o(),
        .srx_valid_o(), .stx_data_o(), .stx_left_i(tr), .stx_right_i(tl), .stx_taken_o());
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic wb(input logic w, input logic [7:0] a, d);
        @(posedge sys_clk_i);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 24'h0, d};
        do @(posedge sys_clk_i); while (ack !== 1'b1);
        q = rdat;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            complete_run;
        end
        if (pv === 1'b1) begin
            `CHK(pl, ql[0])
            `CHK(pr, ql[1])
            ql.delete(0);
            ql.delete(0);
        end
    end
    initial begin
        int wl;
        repeat (6) @(posedge sys_clk_i);
        rst_b_i <= 1;
        for (int i = 0; i < 3; i++) begin
            wb(0, 8'(8'h30 + 4 * i), 0);
            `CHK(q, 32'h0000000a)
        end
        wb(0, 8'h40, 0);
        `CHK(q, 32'h0)
        wb(1, 8'h34, 8'hff);
        wb(0, 8'h34, 0);
        `CHK(q, 32'h0000003f)
        wb(1, 8'h38, 8'hff);
        wb(0, 8'h38, 0);
        `CHK(q, 32'h0000007f)
        for (wl = 2; wl >= 0; wl--) begin
            wb(1, 8'h30, 8'(4 * wl + 2));
            m = 24'hffffff << (8 - 4 * wl);
            repeat (2) begin
                @(posedge sys_clk_i);
                seed = lfsr(seed);
                l = seed[23:0];
                seed = lfsr(seed);
                r = seed[23:0];
                {tl, tr} <= {l, r};
                ql.push_back({l & m, ~l & m, l & m});
                ql.push_back({r & m, ~r & m, r & m});
                host_u.frame(l, r, wl ? 32 : 16);
            end
        end
        @(posedge sys_clk_i);
        host_u.frame(0, 0, 16);
        wb(0, 8'h3c, 0);
        `CHK(q, 32'h00000003)
        repeat (20) @(posedge sys_clk_i);
        `CHK(ql.size(), 0)
        complete_run;
    end
endmodule
